// file: rtl/usr_pkg.sv
// Constants, carrier types and shared helpers of the serial receive block.
// Assumes configuration inputs are held static while the receiver is enabled.
//
// How it works
// - Shift bits after valid start, ignore second stop
// - Stop bit moves frame to buffer, flag set
// - Unused upper data bits read as zero
// - Frame, overrun, parity flags stored with each frame
// - Overrun set when full buffer gets overwritten
// - Parity error when computed parity mismatches bit
// - Reading low word pops buffer
// - Nine-bit low-first mode: high word read pops
// - Disable flushes buffer, drops frame in progress
// - Clock pin direction selects master or slave
// - Inversion selects launch and sample clock edges
// - Slave rate set by external clock only
// - SPI frame is eight bits, no framing bits
// - Bit order select picks LSB or MSB first
// - SPI clock from rate generator, mid-period sample
// - Inversion and phase select SPI sample edges
// - SPI mode error flags always read zero
// - No collision, double-speed, multi-master or select
// - Async normal samples sixteen, double samples eight
// - Shift register feeds two-frame receive buffer
// - Speed code zero normal, code one double
// - Only first stop sampled, low sets frame error
package usr_pkg;

  localparam logic [1:0]  MODE_ASYNC   = 2'h0;
  localparam logic [1:0]  MODE_SYNC    = 2'h1;
  localparam logic [1:0]  MODE_SPI     = 2'h3;

  localparam logic [2:0]  CHSZ_5       = 3'h0;
  localparam logic [2:0]  CHSZ_6       = 3'h1;
  localparam logic [2:0]  CHSZ_7       = 3'h2;
  localparam logic [2:0]  CHSZ_8       = 3'h3;
  localparam logic [2:0]  CHSZ_9H      = 3'h6;
  localparam logic [2:0]  CHSZ_9L      = 3'h7;

  localparam logic [1:0]  PAR_EVEN     = 2'h2;
  localparam logic [1:0]  PAR_ODD      = 2'h3;

  localparam logic [1:0]  SPEED_NORMAL = 2'h0;
  localparam logic [1:0]  SPEED_DOUBLE = 2'h1;

  // Last sample index per bit and index of the deciding vote sample
  localparam logic [3:0]  LAST_NORMAL  = 4'hF;
  localparam logic [3:0]  LAST_DOUBLE  = 4'h7;
  localparam logic [3:0]  VOTE_NORMAL  = 4'h9;
  localparam logic [3:0]  VOTE_DOUBLE  = 4'h5;

  localparam logic [16:0] FRAC_STEP    = 17'h00040;
  localparam logic [3:0]  SPI_BITS     = 4'h8;
  localparam logic [1:0]  FIFO_DEPTH   = 2'h2;

  // Bit positions of the high data word
  localparam int          HI_RXC       = 7;
  localparam int          HI_OVF       = 6;
  localparam int          HI_FRAME_ERROR_FLAG      = 2;
  localparam int          HI_PARITY_ERROR_FLAG      = 1;
  localparam int          HI_D8        = 0;

  typedef enum logic [2:0] {ST_IDLE, ST_START, ST_DATA, ST_PAR, ST_STOP} usr_state_t;

  typedef struct packed {
    logic        rx_en;
    logic [1:0]  comm_mode;
    logic        xck_dir;
    logic        pin_invert_enable;
    logic        clock_phase_select;
    logic        bit_order_select;
    logic [2:0]  char_size_field;
    logic [1:0]  parity_mode;
    logic [1:0]  receive_speed_select;
    logic [15:0] baud;
  } usr_cfg_t;

  typedef struct packed {
    logic        ovf;
    logic        frame_error_flag;
    logic        parity_error_flag;
    logic [8:0]  data;
  } usr_entry_t;

  typedef struct packed {
    logic             rx_meta;
    logic             rx_s;
    logic [16:0]      acc;
    logic [3:0]       sc;
    logic [2:0]       hist;
    usr_state_t       st;
    logic [3:0]       cnt;
    logic [8:0]       data;
    logic             par;
    logic [9:0]       hcnt;
    logic             ph;
    logic             spi_act;
    logic [2:0]       tog_sync;
    logic [1:0]       fill;
    usr_entry_t [1:0] fifo;
    logic [7:0]       lo;
    logic [7:0]       hi;
    logic             rxc;
    logic             transfer_clock_pin;
    logic             xck_oe;
  } usr_core_t;

  typedef struct packed {
    logic       en_meta;
    logic       en_s;
    usr_state_t st;
    logic [3:0] cnt;
    logic [8:0] data;
    logic       par;
    usr_entry_t word;
    logic       tog;
  } usr_link_t;

  function automatic logic [3:0] char_bits(input logic [2:0] chsz);
    case (chsz)
      CHSZ_5: char_bits = 4'h5;
      CHSZ_6: char_bits = 4'h6;
      CHSZ_7: char_bits = 4'h7;
      CHSZ_9H,
      CHSZ_9L: char_bits = 4'h9;
      default: char_bits = 4'h8;
    endcase
  endfunction

  function automatic logic parity_bad(input logic [8:0] d, input logic p, input logic [1:0] pm);
    parity_bad = pm[1] & ((^d) ^ p ^ (pm == PAR_ODD));
  endfunction

endpackage

// file: rtl/usr_rx.sv
// Receive path of the serial port with sync slave, sync master and SPI master.
// Assumes cfg static while rx_en is high; link_clk is the external transfer clock.
`timescale 1ns/1ps
`default_nettype none
module usr_rx (
  // Core clock, reset, enable
  input  wire logic              core_clk,
  input  wire logic              nrst,
  input  wire logic              ce,
  // Configuration
  input  wire usr_pkg::usr_cfg_t cfg,
  input  wire logic              spi_start,
  // Data register reads
  input  wire logic              rd_low,
  input  wire logic              rd_high,
  // Pins
  input  wire logic              rxd,
  input  wire logic              link_clk,
  output logic                   xck_out,
  output logic                   xck_oe,
  // Received data
  output logic [7:0]             rx_word_low,
  output logic [7:0]             rx_word_high,
  output logic                   rx_complete_flag
);

  usr_pkg::usr_core_t  s;
  usr_pkg::usr_core_t  n;
  usr_pkg::usr_link_t  l;
  usr_pkg::usr_link_t  ln;

  logic                is_async;
  logic                is_spi;
  logic                is_master;
  logic                is_slave;
  logic                nine_l;
  logic [3:0]          nb;
  logic [3:0]          last;
  logic [3:0]          vpt;
  logic [16:0]         acc_nx;
  logic                strobe;
  logic                bval;
  logic                edge_ev;
  logic                samp_lead;
  logic                done;
  logic                pop;
  logic [3:0]          idx;
  logic [1:0]          fl;
  usr_pkg::usr_entry_t ent;
  usr_pkg::usr_entry_t [1:0] f;
  logic                samp_clk;

  assign is_async  = cfg.comm_mode == usr_pkg::MODE_ASYNC;
  assign is_spi    = cfg.comm_mode == usr_pkg::MODE_SPI;
  assign is_master = is_spi | ((cfg.comm_mode == usr_pkg::MODE_SYNC) & cfg.xck_dir);
  assign is_slave  = (cfg.comm_mode == usr_pkg::MODE_SYNC) & ~cfg.xck_dir;
  assign nine_l    = cfg.char_size_field == usr_pkg::CHSZ_9L;
  assign nb        = is_spi ? usr_pkg::SPI_BITS : usr_pkg::char_bits(cfg.char_size_field);
  // Slave samples on falling edge, or rising when inverted
  assign samp_clk  = link_clk ^ ~cfg.pin_invert_enable;

  always_comb begin
    n       = s;
    strobe  = 1'b0;
    bval    = 1'b0;
    edge_ev = 1'b0;
    done    = 1'b0;
    idx     = 4'h0;
    ent     = '0;
    n.rx_meta  = rxd;
    n.rx_s     = s.rx_meta;
    n.tog_sync = {s.tog_sync[1], s.tog_sync[0], l.tog};

    // Fractional sample-rate generator for asynchronous reception
    last = (cfg.receive_speed_select == usr_pkg::SPEED_DOUBLE) ?
           usr_pkg::LAST_DOUBLE : usr_pkg::LAST_NORMAL;
    vpt  = (cfg.receive_speed_select == usr_pkg::SPEED_DOUBLE) ?
           usr_pkg::VOTE_DOUBLE : usr_pkg::VOTE_NORMAL;
    acc_nx = s.acc + usr_pkg::FRAC_STEP;
    if (acc_nx >= {1'b0, cfg.baud}) begin
      n.acc = acc_nx - {1'b0, cfg.baud};
      if (is_async && cfg.rx_en) begin
        n.hist = {s.hist[1:0], s.rx_s};
        if (s.st == usr_pkg::ST_IDLE) begin
          if (!s.rx_s) begin
            n.st = usr_pkg::ST_START;
            n.sc = 4'h1;
          end
        end else begin
          n.sc = (s.sc == last) ? 4'h0 : s.sc + 4'h1;
          if (s.sc == vpt) begin
            strobe = 1'b1;
            bval   = (n.hist[0] & n.hist[1]) | (n.hist[1] & n.hist[2]) |
                     (n.hist[0] & n.hist[2]);
          end
        end
      end
    end else begin
      n.acc = acc_nx;
    end

    // Master transfer clock: half period from integer part of the divisor
    samp_lead = is_spi & ~cfg.clock_phase_select;
    if (cfg.rx_en && ((is_master && !is_spi) || (is_spi && s.spi_act))) begin
      if (({1'b0, s.hcnt} + 11'h001) >= {1'b0, cfg.baud[15:6]}) begin
        n.hcnt  = 10'h000;
        n.ph    = ~s.ph;
        edge_ev = 1'b1;
        if ((~s.ph) == samp_lead) begin
          strobe = 1'b1;
          bval   = s.rx_s;
        end
      end else begin
        n.hcnt = s.hcnt + 10'h001;
      end
    end else begin
      n.hcnt = 10'h000;
      n.ph   = 1'b0;
    end

    // Frame assembly shared by async and master modes
    if (strobe) begin
      case (s.st)
        usr_pkg::ST_IDLE: begin
          if (!bval && !is_spi && !is_async) begin
            n.st   = usr_pkg::ST_DATA;
            n.cnt  = 4'h0;
            n.data = '0;
          end
        end
        usr_pkg::ST_START: begin
          if (!bval) begin
            n.st   = usr_pkg::ST_DATA;
            n.cnt  = 4'h0;
            n.data = '0;
          end else begin
            n.st = usr_pkg::ST_IDLE;
          end
        end
        usr_pkg::ST_DATA: begin
          idx = (is_spi && cfg.bit_order_select) ? (4'h7 - s.cnt) : s.cnt;
          n.data[idx] = bval;
          n.cnt = s.cnt + 4'h1;
          if (s.cnt == nb - 4'h1) begin
            if (is_spi) begin
              done = 1'b1;
              n.st = usr_pkg::ST_IDLE;
            end else begin
              n.st = cfg.parity_mode[1] ? usr_pkg::ST_PAR : usr_pkg::ST_STOP;
            end
          end
        end
        usr_pkg::ST_PAR: begin
          n.par = bval;
          n.st  = usr_pkg::ST_STOP;
        end
        usr_pkg::ST_STOP: begin
          done     = 1'b1;
          ent.frame_error_flag = ~bval;
          n.st     = usr_pkg::ST_IDLE;
        end
        default: n.st = usr_pkg::ST_IDLE;
      endcase
    end
    ent.data = n.data;
    ent.parity_error_flag = ~is_spi & usr_pkg::parity_bad(n.data, n.par, cfg.parity_mode);
    if (is_spi) begin
      ent.frame_error_flag = 1'b0;
    end

    // SPI frame: clock starts on request, stops after the last full cycle
    if (s.spi_act && edge_ev && s.ph && n.st == usr_pkg::ST_IDLE) begin
      n.spi_act = 1'b0;
    end
    if (spi_start && cfg.rx_en && is_spi && !s.spi_act) begin
      n.spi_act = 1'b1;
      n.st      = usr_pkg::ST_DATA;
      n.cnt     = 4'h0;
      n.data    = '0;
      n.hcnt    = 10'h000;
      n.ph      = 1'b0;
    end

    // Frames finished in the slave clock domain
    if (is_slave && cfg.rx_en && (s.tog_sync[2] != s.tog_sync[1])) begin
      done = 1'b1;
      ent  = l.word;
    end

    // Two-entry receive buffer
    pop = nine_l ? rd_high : rd_low;
    f   = s.fifo;
    fl  = s.fill;
    if (pop && fl != 2'h0) begin
      f[0] = f[1];
      fl   = fl - 2'h1;
    end
    if (done) begin
      if (fl == usr_pkg::FIFO_DEPTH) begin
        ent.ovf = ~is_spi;
        f[1]    = ent;
      end else begin
        f[fl[0]] = ent;
        fl       = fl + 2'h1;
      end
    end
    if (!cfg.rx_en) begin
      fl        = 2'h0;
      n.st      = usr_pkg::ST_IDLE;
      n.spi_act = 1'b0;
    end
    n.fifo = f;
    n.fill = fl;

    // Registered read view of the buffer head
    n.rxc = fl != 2'h0;
    n.lo  = n.rxc ? f[0].data[7:0] : 8'h00;
    n.hi  = 8'h00;
    n.hi[usr_pkg::HI_RXC]  = n.rxc;
    n.hi[usr_pkg::HI_OVF]  = n.rxc & f[0].ovf;
    n.hi[usr_pkg::HI_FRAME_ERROR_FLAG] = n.rxc & f[0].frame_error_flag;
    n.hi[usr_pkg::HI_PARITY_ERROR_FLAG] = n.rxc & f[0].parity_error_flag;
    n.hi[usr_pkg::HI_D8]   = n.rxc & f[0].data[8];
    n.transfer_clock_pin    = n.ph ^ cfg.pin_invert_enable;
    n.xck_oe = is_master;
  end

  always_ff @(posedge core_clk) begin
    if (!nrst) begin
      s <= '0;
    end else if (ce) begin
      s <= n;
    end
  end

  // Slave-mode frame assembly on the external transfer clock
  always_comb begin
    ln         = l;
    ln.en_meta = cfg.rx_en & is_slave;
    ln.en_s    = l.en_meta;
    if (!l.en_s) begin
      ln.st  = usr_pkg::ST_IDLE;
      ln.tog = 1'b0;
    end else begin
      case (l.st)
        usr_pkg::ST_IDLE: begin
          if (!rxd) begin
            ln.st   = usr_pkg::ST_DATA;
            ln.cnt  = 4'h0;
            ln.data = '0;
          end
        end
        usr_pkg::ST_DATA: begin
          ln.data[l.cnt] = rxd;
          ln.cnt = l.cnt + 4'h1;
          if (l.cnt == nb - 4'h1) begin
            ln.st = cfg.parity_mode[1] ? usr_pkg::ST_PAR : usr_pkg::ST_STOP;
          end
        end
        usr_pkg::ST_PAR: begin
          ln.par = rxd;
          ln.st  = usr_pkg::ST_STOP;
        end
        usr_pkg::ST_STOP: begin
          ln.word.data = l.data;
          ln.word.frame_error_flag = ~rxd;
          ln.word.parity_error_flag = usr_pkg::parity_bad(l.data, l.par, cfg.parity_mode);
          ln.word.ovf  = 1'b0;
          ln.tog       = ~l.tog;
          ln.st        = usr_pkg::ST_IDLE;
        end
        default: ln.st = usr_pkg::ST_IDLE;
      endcase
    end
  end

  always_ff @(posedge samp_clk) begin
    l <= ln;
  end

  assign xck_out          = s.transfer_clock_pin;
  assign xck_oe           = s.xck_oe;
  assign rx_word_low      = s.lo;
  assign rx_word_high     = s.hi;
  assign rx_complete_flag = s.rxc;

endmodule
`default_nettype wire

// file: sim/usr_tx_model.sv
// Remote synchronous master: drives transfer clock and serial frames.
// Assumes base_clk is the link reference; clock toggles during idle bits and frames, rests otherwise.
`timescale 1ns/1ps
`default_nettype none
module usr_tx_model (
  // Reference clock
  input  wire logic base_clk,
  // Master clock seen by the slave reply
  input  wire logic transfer_clock_pin,
  // Pins
  output logic      rxd,
  output logic      link_clk
);
  initial begin
    rxd      = 1'h1;
    link_clk = 1'h0;
  end
  // Eight reference cycles per bit keep the clock under a quarter core rate
  task automatic half();
    repeat (4) @(posedge base_clk);
  endtask
  task automatic bit_out(input logic b, input logic inv);
    link_clk = ~inv;
    rxd      = b;
    half();
    link_clk = inv;
    half();
  endtask
  task automatic idle(input int n, input logic inv);
    link_clk = inv;
    repeat (n) bit_out(1'h1, inv);
  endtask
  task automatic frame(input logic [8:0] d, input int nb, input logic [1:0] pm,
                       input logic flip, input logic sbad, input logic inv);
    logic p;
    p = pm[0] ^ flip;
    bit_out(1'h0, inv);
    for (int i = 0; i < nb; i++) begin
      bit_out(d[i], inv);
      p = p ^ d[i];
    end
    if (pm[1]) bit_out(p, inv);
    bit_out(~sbad, inv);
    bit_out(1'h1, inv);
  endtask
  // SPI slave reply: next bit launched on each trailing falling edge
  task automatic spi_reply(input logic [7:0] d, input logic msb);
    for (int i = 0; i < 8; i++) begin
      rxd = msb ? d[7 - i] : d[i];
      @(negedge transfer_clock_pin);
    end
    rxd = 1'h1;
  endtask
  // Asynchronous frame, eight data bits, no parity, bit time in ns
  task automatic async_frame(input logic [7:0] d, input int bit_ns);
    rxd = 1'h0;
    #(bit_ns);
    for (int i = 0; i < 8; i++) begin
      rxd = d[i];
      #(bit_ns);
    end
    rxd = 1'h1;
    #(2 * bit_ns);
  endtask
endmodule
`default_nettype wire

// file: sim/usr_rx_chk.sv
// Port checker of the receive block.
// Assumes cfg only changes while the receiver is disabled.
`timescale 1ns/1ps
`default_nettype none
module usr_rx_chk (
  // Clock and reset
  input wire logic              core_clk,
  input wire logic              nrst,
  input wire logic              ce,
  // Controls
  input wire usr_pkg::usr_cfg_t cfg,
  input wire logic              spi_start,
  input wire logic              rd_low,
  input wire logic              rd_high,
  // Pins and results
  input wire logic              rxd,
  input wire logic              link_clk,
  input wire logic              xck_out,
  input wire logic              xck_oe,
  input wire logic [7:0]        rx_word_low,
  input wire logic [7:0]        rx_word_high,
  input wire logic              rx_complete_flag
);
  default clocking cb @(posedge core_clk); endclocking
  default disable iff (!nrst);
  a_flag_bit: assert property (rx_complete_flag == rx_word_high[7])
    else $error("complete flag and high word differ");
  a_empty_zero: assert property (!rx_complete_flag |->
    {rx_word_low, rx_word_high} == 16'h0000)
    else $error("empty buffer shows data");
  a_disable_flush: assert property (!cfg.rx_en && ce |=> !rx_complete_flag)
    else $error("disable left data");
  a_spi_no_err: assert property (cfg.rx_en && cfg.comm_mode == usr_pkg::MODE_SPI |->
    rx_word_high[6:1] == 6'h00)
    else $error("error flag in spi mode");
  a_xck_role: assert property ((cfg.rx_en && cfg.comm_mode == usr_pkg::MODE_SYNC) [*3] |->
    xck_oe == cfg.xck_dir)
    else $error("clock pin role wrong");
  a_keep_nonpop: assert property (cfg.rx_en && rx_complete_flag && (rd_low != rd_high) &&
    (rd_high == (cfg.char_size_field != usr_pkg::CHSZ_9L)) |=> rx_complete_flag)
    else $error("read without pop emptied buffer");
  a_head_hold: assert property (rx_complete_flag && !rd_low && !rd_high && cfg.rx_en |=>
    $stable(rx_word_low))
    else $error("head changed without pop");
  a_upper_zero: assert property (rx_complete_flag &&
    cfg.char_size_field == usr_pkg::CHSZ_5 |-> rx_word_low[7:5] == 3'h0)
    else $error("unused bits not zero");
  a_hi_unused: assert property (rx_word_high[5:3] == 3'h0)
    else $error("unused high bits set");
  c_frame: cover property ($rose(rx_complete_flag));
  c_ovf: cover property (rx_word_high[6]);
  c_spi: cover property (cfg.comm_mode == usr_pkg::MODE_SPI && rx_complete_flag);
  c_async: cover property (cfg.comm_mode == usr_pkg::MODE_ASYNC && rx_complete_flag);
endmodule
bind usr_rx usr_rx_chk u_chk (.core_clk(core_clk), .nrst(nrst), .ce(ce), .cfg(cfg),
  .spi_start(spi_start), .rd_low(rd_low), .rd_high(rd_high), .rxd(rxd), .link_clk(link_clk),
  .xck_out(xck_out), .xck_oe(xck_oe), .rx_word_low(rx_word_low), .rx_word_high(rx_word_high),
  .rx_complete_flag(rx_complete_flag));
`default_nettype wire

// file: sim/tb.sv
// Testbench of the receive block with a synchronous master model.
// Assumes the design package is compiled first.
`timescale 1ns/1ps
`default_nettype none
`define CHK(a, b) begin samples_checked++; if ((a) !== (b)) begin err_total++; \
  $display("mismatch t=%0t got=%h exp=%h", $time, a, b); end end
module tb;
  typedef struct packed {
    logic [2:0] cs;
    logic [3:0] nb;
    logic [1:0] pm;
    logic       inv;
    logic       flip;
    logic       sbad;
    logic [8:0] d;
    logic [7:0] elo;
    logic [7:0] ehi;
  } usr_row_t;
  usr_row_t rows [7] = '{
    '{3'h0, 4'h5, 2'h0, 1'h0, 1'h0, 1'h0, 9'h0F6, 8'h16, 8'h80},
    '{3'h1, 4'h6, 2'h0, 1'h0, 1'h0, 1'h0, 9'h0ED, 8'h2D, 8'h80},
    '{3'h2, 4'h7, 2'h2, 1'h1, 1'h0, 1'h0, 9'h055, 8'h55, 8'h80},
    '{3'h3, 4'h8, 2'h3, 1'h0, 1'h1, 1'h0, 9'h0A5, 8'hA5, 8'h82},
    '{3'h3, 4'h8, 2'h0, 1'h0, 1'h0, 1'h1, 9'h03C, 8'h3C, 8'h84},
    '{3'h6, 4'h9, 2'h0, 1'h1, 1'h0, 1'h0, 9'h1C3, 8'hC3, 8'h81},
    '{3'h7, 4'h9, 2'h0, 1'h0, 1'h0, 1'h0, 9'h15A, 8'h5A, 8'h81}};
  usr_pkg::usr_cfg_t cfg;
  logic       core_clk, base_clk, nrst, ce, spi_start, rd_low, rd_high;
  logic       rxd, link_clk, xck_out, xck_oe, flag, px;
  logic [7:0] lo, hi;
  int         err_total, samples_checked, cyc, k, n;
  usr_rx DUT (.core_clk(core_clk), .nrst(nrst), .ce(ce), .cfg(cfg), .spi_start(spi_start),
    .rd_low(rd_low), .rd_high(rd_high), .rxd(rxd), .link_clk(link_clk), .xck_out(xck_out),
    .xck_oe(xck_oe), .rx_word_low(lo), .rx_word_high(hi), .rx_complete_flag(flag));
  usr_tx_model P (.base_clk(base_clk), .transfer_clock_pin(xck_out), .rxd(rxd), .link_clk(link_clk));
  initial begin
    core_clk = 1'h0;
    forever #10 core_clk = ~core_clk;
  end
  initial begin
    base_clk = 1'h0;
    #3;
    forever #6 base_clk = ~base_clk;
  end
  task automatic final_report();
    $display("checked=%0d errors=%0d", samples_checked, err_total);
    if (err_total == 0 && samples_checked > 0) $display("No errors found");
    else $display("Errors were found");
    $finish;
  endtask
  always @(posedge core_clk) begin
    cyc++;
    if (cyc == 20000) begin
      err_total++;
      final_report();
    end
  end
  task automatic tick();
    @(posedge core_clk);
    #2;
  endtask
  task automatic waitf();
    k = 0;
    while (flag !== 1'h1 && k < 300) begin
      tick();
      k++;
    end
  endtask
  task automatic setup(input logic [2:0] cs, input logic [1:0] pm, input logic inv);
    cfg.rx_en = 1'h0;
    tick();
    cfg.char_size_field = cs;
    cfg.parity_mode = pm;
    cfg.pin_invert_enable = inv;
    P.idle(3, inv);
    tick();
    cfg.rx_en = 1'h1;
    P.idle(3, inv);
  endtask
  task automatic pop(input logic lf);
    if (lf) rd_low = 1'h1;
    else rd_high = 1'h1;
    tick();
    rd_low = 1'h0;
    rd_high = 1'h0;
    tick();
    `CHK(flag, 1'h1)
    if (lf) rd_high = 1'h1;
    else rd_low = 1'h1;
    tick();
    rd_low = 1'h0;
    rd_high = 1'h0;
    tick();
  endtask
  initial begin
    {nrst, spi_start, rd_low, rd_high} = 4'h0;
    ce = 1'h1;
    cfg = '0;
    cfg.comm_mode = usr_pkg::MODE_SYNC;
    cfg.baud = 16'h0040;
    repeat (2) tick();
    `CHK({flag, lo, hi}, 17'h00000)
    nrst = 1'h1;
    foreach (rows[i]) begin
      setup(rows[i].cs, rows[i].pm, rows[i].inv);
      P.frame(rows[i].d, rows[i].nb, rows[i].pm, rows[i].flip, rows[i].sbad, rows[i].inv);
      waitf();
      `CHK(lo, rows[i].elo)
      `CHK(hi, rows[i].ehi)
      pop(rows[i].cs == usr_pkg::CHSZ_9L);
      `CHK(flag, 1'h0)
    end
    setup(usr_pkg::CHSZ_8, 2'h0, 1'h0);
    for (int j = 1; j < 4; j++) P.frame(9'(j * 17), 8, 2'h0, 1'h0, 1'h0, 1'h0);
    repeat (10) tick();
    `CHK({lo, hi}, 16'h1180)
    pop(1'h0);
    `CHK({lo, hi}, 16'h33C0)
    P.frame(9'h044, 8, 2'h0, 1'h0, 1'h0, 1'h0);
    repeat (10) tick();
    cfg.rx_en = 1'h0;
    repeat (2) tick();
    `CHK({flag, lo}, 9'h000)
    cfg.comm_mode = usr_pkg::MODE_SPI;
    cfg.baud = 16'h0100;
    cfg.bit_order_select = 1'h1;
    tick();
    cfg.rx_en = 1'h1;
    tick();
    fork
      P.spi_reply(8'hB4, 1'h1);
    join_none
    tick();
    spi_start = 1'h1;
    tick();
    spi_start = 1'h0;
    n = 0;
    k = 0;
    px = xck_out;
    while (flag !== 1'h1 && k < 300) begin
      tick();
      k++;
      if (xck_out === 1'h1 && px === 1'h0) n++;
      px = xck_out;
    end
    `CHK(n, 8)
    `CHK({xck_oe, lo, hi}, 17'h1B480)
    cfg.comm_mode = usr_pkg::MODE_ASYNC;
    cfg.baud = 16'h0040;
    for (int m = 0; m < 2; m++) begin
      cfg.rx_en = 1'h0;
      cfg.receive_speed_select = 2'(m);
      tick();
      cfg.rx_en = 1'h1;
      repeat (4) tick();
      P.async_frame(8'h69, (m == 0) ? 320 : 160);
      waitf();
      `CHK({lo, hi}, 16'h6980)
    end
    final_report();
  end
endmodule
`default_nettype wire
